// File: hdl/mudb_top.v
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mudb_defs.vh"
module mudb_top (
   // Clock and reset
   input wire SYS_CLK_I,
   input wire RSTN_I,
   // Core side APB slave
   input wire PSEL_I,
   input wire PENABLE_I,
   input wire PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   output reg [31:0] PRDATA_O,
   output wire PREADY_O,
   output wire PSLVERR_O,
   // PCI target side, fed from the translation unit queues
   input wire P_VALID_I,
   input wire P_WRITE_I,
   input wire [11:0] P_ADDR_I,
   input wire [31:0] P_WDATA_I,
   input wire [3:0] P_BE_I,
   input wire P_REQ64_I,
   output wire P_READY_O,
   output reg [31:0] P_RDATA_O,
   output reg P_ACK64_O,
   // Translation unit status
   input wire XLAT_IWQ_EMPTY_I,
   input wire [7:0] XLAT_INT_PIN_I,
   // Circular queue ports toward the queue engine
   output reg IPQ_WR_O,
   output reg [31:0] IPQ_DATA_O,
   output reg IFQ_RD_O,
   input wire [31:0] IFQ_DATA_I,
   output reg OPQ_RD_O,
   input wire [31:0] OPQ_DATA_I,
   output reg OFQ_WR_O,
   output reg [31:0] OFQ_DATA_O,
   // Interrupts
   output reg CORE_IRQ_O,
   output reg CORE_NMI_O,
   output wire [3:0] P_INT_O,
   output wire [3:0] P_INT_OE_N_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   reg [31:0] imr0_q;
   reg [31:0] imr1_q;
   reg [31:0] omr0_q;
   reg [31:0] omr1_q;
   reg [`MUDB_ST_W-1:0] iimr_q;
   reg [`MUDB_ST_W-1:0] oimr_q;
   reg [31:0] odmr_q;
   reg ipq_pend_q;
   reg p_ready_q;
   reg pci_irq_q;

   wire [31:0] idr;
   wire [31:0] odr;
   wire [`MUDB_ST_W-1:0] iisr_st;
   wire [`MUDB_ST_W-1:0] oisr_st;

   reg [31:0] idr_set;
   reg [31:0] idr_clr;
   reg [31:0] odr_set;
   reg [31:0] odr_clr;
   reg [`MUDB_ST_W-1:0] iisr_set;
   reg [`MUDB_ST_W-1:0] iisr_clr;
   reg [`MUDB_ST_W-1:0] oisr_set;
   reg [`MUDB_ST_W-1:0] oisr_clr;

   wire [`MUDB_ST_W-1:0] iisr_rd;
   wire [`MUDB_ST_W-1:0] oisr_rd;
   wire c_setup;
   wire c_wr;
   wire c_hit;
   wire p_take;
   wire p_wr;
   wire p_rd;
   wire p_nullbe;
   wire p_is_q;
   wire ipq_ev;
   wire core_irq_d;
   wire pci_irq_d;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode and read mux

   function mapped;
      input [11:0] a;
      begin
         case (a)
            `MUDB_IMR0_OFS, `MUDB_IMR1_OFS, `MUDB_OMR0_OFS, `MUDB_OMR1_OFS,
            `MUDB_IDR_OFS, `MUDB_IISR_OFS, `MUDB_IIMR_OFS, `MUDB_ODR_OFS,
            `MUDB_OISR_OFS, `MUDB_OIMR_OFS, `MUDB_ODMR_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   function [31:0] rd_mux;
      input [11:0] a;
      begin
         case (a)
            `MUDB_IMR0_OFS: rd_mux = imr0_q;
            `MUDB_IMR1_OFS: rd_mux = imr1_q;
            `MUDB_OMR0_OFS: rd_mux = omr0_q;
            `MUDB_OMR1_OFS: rd_mux = omr1_q;
            `MUDB_IDR_OFS: rd_mux = idr;
            `MUDB_IISR_OFS: rd_mux = {27'h0, iisr_rd};
            `MUDB_IIMR_OFS: rd_mux = {27'h0, iimr_q};
            `MUDB_ODR_OFS: rd_mux = odr;
            `MUDB_OISR_OFS: rd_mux = {27'h0, oisr_rd};
            `MUDB_OIMR_OFS: rd_mux = {27'h0, oimr_q};
            `MUDB_ODMR_OFS: rd_mux = odmr_q;
            default: rd_mux = 32'h00000000;
         endcase
      end
   endfunction

   // Doorbell summary bits are live views, not stored flags
   assign iisr_rd = {iisr_st[`MUDB_ST_POST], idr[`MUDB_NMI_BIT], |idr[30:0],
                     iisr_st[`MUDB_ST_MSG1:`MUDB_ST_MSG0]};
   assign oisr_rd = {2'h0, |odr, oisr_st[`MUDB_ST_MSG1:`MUDB_ST_MSG0]};

   ////////////////////////////////////////////////////////////////////////////////
   // Core side APB: zero wait states, read data captured in the setup cycle

   assign c_setup = PSEL_I & ~PENABLE_I;
   assign c_wr = PSEL_I & PENABLE_I & PWRITE_I;
   assign c_hit = mapped(PADDR_I);
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~c_hit;

   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PRDATA_O <= `MUDB_REG_RST;
      end else if (c_setup) begin
         PRDATA_O <= rd_mux(PADDR_I);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // PCI side: one request per two cycles, answer registered

   // Every message and doorbell access already came through the ordinary queues
   assign p_take = P_VALID_I & ~p_ready_q;
   assign p_wr = p_take & P_WRITE_I;
   assign p_rd = p_take & ~P_WRITE_I;
   // Null byte enables on a queue port raise no queue strobe, though OFQ_DATA_O still takes the write data
   assign p_nullbe = (P_BE_I == 4'h0);
   assign p_is_q = (P_ADDR_I == `MUDB_IQP_OFS) | (P_ADDR_I == `MUDB_OQP_OFS);
   assign P_READY_O = p_ready_q;

   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         p_ready_q <= 1'b0;
         P_RDATA_O <= `MUDB_REG_RST;
         P_ACK64_O <= 1'b0;
      end else begin
         p_ready_q <= p_take;
         P_ACK64_O <= p_take & P_REQ64_I & ~p_is_q;
         if (p_rd) begin
            if (P_ADDR_I == `MUDB_IQP_OFS) begin
               P_RDATA_O <= IFQ_DATA_I;
            end else if (P_ADDR_I == `MUDB_OQP_OFS) begin
               P_RDATA_O <= OPQ_DATA_I;
            end else begin
               P_RDATA_O <= rd_mux(P_ADDR_I);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Circular queue ports

   // Inbound: agents read free and write post; outbound: read post, write free
   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         IPQ_WR_O <= 1'b0;
         IFQ_RD_O <= 1'b0;
         OPQ_RD_O <= 1'b0;
         OFQ_WR_O <= 1'b0;
         IPQ_DATA_O <= `MUDB_REG_RST;
         OFQ_DATA_O <= `MUDB_REG_RST;
      end else begin
         IPQ_WR_O <= ipq_ev;
         IFQ_RD_O <= p_rd & ~p_nullbe & (P_ADDR_I == `MUDB_IQP_OFS);
         OPQ_RD_O <= p_rd & ~p_nullbe & (P_ADDR_I == `MUDB_OQP_OFS);
         // No ordering hardware on the free queues or outbound post
         OFQ_WR_O <= p_wr & ~p_nullbe & (P_ADDR_I == `MUDB_OQP_OFS);
         if (ipq_ev) begin
            IPQ_DATA_O <= P_WDATA_I;
         end
         if (p_wr & (P_ADDR_I == `MUDB_OQP_OFS)) begin
            OFQ_DATA_O <= P_WDATA_I;
         end
      end
   end

   assign ipq_ev = p_wr & ~p_nullbe & (P_ADDR_I == `MUDB_IQP_OFS);

   // The post flag waits until earlier posted writes have drained to memory
   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ipq_pend_q <= 1'b0;
      end else begin
         ipq_pend_q <= ipq_ev | (ipq_pend_q & ~XLAT_IWQ_EMPTY_I);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Message registers and masks

   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         imr0_q <= `MUDB_REG_RST;
         imr1_q <= `MUDB_REG_RST;
         omr0_q <= `MUDB_REG_RST;
         omr1_q <= `MUDB_REG_RST;
         iimr_q <= `MUDB_ST_RST;
         oimr_q <= `MUDB_ST_RST;
         odmr_q <= `MUDB_REG_RST;
      end else begin
         if (p_wr & (P_ADDR_I == `MUDB_IMR0_OFS)) begin
            imr0_q <= P_WDATA_I;
         end
         if (p_wr & (P_ADDR_I == `MUDB_IMR1_OFS)) begin
            imr1_q <= P_WDATA_I;
         end
         if (c_wr & (PADDR_I == `MUDB_OMR0_OFS)) begin
            omr0_q <= PWDATA_I;
         end
         if (c_wr & (PADDR_I == `MUDB_OMR1_OFS)) begin
            omr1_q <= PWDATA_I;
         end
         if (c_wr & (PADDR_I == `MUDB_IIMR_OFS)) begin
            iimr_q <= PWDATA_I[`MUDB_ST_W-1:0];
         end
         // Host owns its own masks
         if (p_wr & (P_ADDR_I == `MUDB_OIMR_OFS)) begin
            oimr_q <= P_WDATA_I[`MUDB_ST_W-1:0];
         end
         if (p_wr & (P_ADDR_I == `MUDB_ODMR_OFS)) begin
            odmr_q <= P_WDATA_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Set and clear terms for flags and doorbells

   always @* begin
      idr_set = 32'h00000000;
      idr_clr = 32'h00000000;
      odr_set = 32'h00000000;
      odr_clr = 32'h00000000;
      iisr_set = `MUDB_ST_RST;
      iisr_clr = `MUDB_ST_RST;
      oisr_set = `MUDB_ST_RST;
      oisr_clr = `MUDB_ST_RST;
      // Inbound doorbell: agent sets only, core clears only
      if (p_wr & (P_ADDR_I == `MUDB_IDR_OFS)) begin
         idr_set = P_WDATA_I;
      end
      if (c_wr & (PADDR_I == `MUDB_IDR_OFS)) begin
         idr_clr = PWDATA_I;
      end
      // Outbound doorbell: core sets only, agent clears only
      if (c_wr & (PADDR_I == `MUDB_ODR_OFS)) begin
         odr_set = PWDATA_I;
      end
      if (p_wr & (P_ADDR_I == `MUDB_ODR_OFS)) begin
         odr_clr = P_WDATA_I;
      end
      iisr_set[`MUDB_ST_MSG0] = p_wr & (P_ADDR_I == `MUDB_IMR0_OFS);
      iisr_set[`MUDB_ST_MSG1] = p_wr & (P_ADDR_I == `MUDB_IMR1_OFS);
      iisr_set[`MUDB_ST_POST] = ipq_pend_q & XLAT_IWQ_EMPTY_I;
      if (c_wr & (PADDR_I == `MUDB_IISR_OFS)) begin
         iisr_clr = PWDATA_I[`MUDB_ST_W-1:0];
      end
      oisr_set[`MUDB_ST_MSG0] = c_wr & (PADDR_I == `MUDB_OMR0_OFS);
      oisr_set[`MUDB_ST_MSG1] = c_wr & (PADDR_I == `MUDB_OMR1_OFS);
      if (p_wr & (P_ADDR_I == `MUDB_OISR_OFS)) begin
         oisr_clr = P_WDATA_I[`MUDB_ST_W-1:0];
      end
   end

   mudb_w1c_reg #(.W(32)) u_idr (
      .clk_i(SYS_CLK_I),
      .rstn_i(RSTN_I),
      .set_i(idr_set),
      .clr_i(idr_clr),
      .q_o(idr)
   );

   mudb_w1c_reg #(.W(32)) u_odr (
      .clk_i(SYS_CLK_I),
      .rstn_i(RSTN_I),
      .set_i(odr_set),
      .clr_i(odr_clr),
      .q_o(odr)
   );

   mudb_w1c_reg #(.W(`MUDB_ST_W)) u_iisr (
      .clk_i(SYS_CLK_I),
      .rstn_i(RSTN_I),
      .set_i(iisr_set),
      .clr_i(iisr_clr),
      .q_o(iisr_st)
   );

   mudb_w1c_reg #(.W(`MUDB_ST_W)) u_oisr (
      .clk_i(SYS_CLK_I),
      .rstn_i(RSTN_I),
      .set_i(oisr_set),
      .clr_i(oisr_clr),
      .q_o(oisr_st)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt outputs

   // Masks gate only the request; the stored bits keep whatever was written
   assign core_irq_d =
      |(iisr_st[`MUDB_ST_MSG1:`MUDB_ST_MSG0] & ~iimr_q[`MUDB_ST_MSG1:`MUDB_ST_MSG0]) |
      ((|idr[30:0]) & ~iimr_q[`MUDB_ST_DB]) |
      (iisr_st[`MUDB_ST_POST] & ~iimr_q[`MUDB_ST_POST]);
   assign pci_irq_d =
      |(oisr_st[`MUDB_ST_MSG1:`MUDB_ST_MSG0] & ~oimr_q[`MUDB_ST_MSG1:`MUDB_ST_MSG0]) |
      (|(odr & ~odmr_q));

   always @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         CORE_IRQ_O <= 1'b0;
         CORE_NMI_O <= 1'b0;
         pci_irq_q <= 1'b0;
      end else begin
         CORE_IRQ_O <= core_irq_d;
         // The top inbound doorbell bit bypasses every mask
         CORE_NMI_O <= idr[`MUDB_NMI_BIT];
         pci_irq_q <= pci_irq_d;
      end
   end

   mudb_pci_irq u_pci_irq (
      .clk_i(SYS_CLK_I),
      .rstn_i(RSTN_I),
      .irq_i(pci_irq_q),
      .pin_sel_i(XLAT_INT_PIN_I),
      .int_o(P_INT_O),
      .int_oe_n_o(P_INT_OE_N_O)
   );

endmodule // mudb_top
`default_nettype wire

// File: include/mudb_defs.vh
// Function
// - Message, doorbell and index accesses arrive through the primary translation unit queues.
// - Inbound post notice waits until the translation unit inbound write queue drains.
// - Other three queues get no special ordering hardware.
// - Outbound message writes may raise a PCI interrupt on the selected pin.
// - Outbound message write sets outbound status flag; PCI clears it by writing one.
// - Inbound message write may interrupt the core unless masked.
// - Inbound message write sets inbound status flag; core clears it by writing one.
// - Core writing ones to outbound doorbell sets those bits and requests PCI interrupt.
// - The core can never clear an outbound doorbell bit.
// - Outbound doorbell mask gates only that bit's interrupt, not the stored value.
// - PCI agent clears outbound doorbell bits by writing ones; zeros change nothing.
// - PCI writing ones sets inbound doorbell bits; PCI can never clear them.
// - Inbound doorbell mask gates only the core interrupt, not the stored bits.
// - One inbound doorbell bit drives a non-maskable core interrupt.
// - Core clears inbound doorbell bits by writing ones; zeros change nothing.
// - Four circular queues: inbound free and post, outbound free and post.
// - Inbound free entries flow out to agents, outbound free entries flow back in.
// - Two inbound and two outbound 32-bit message registers exist.
// - Queue ports are 32-bit only and never acknowledge a 64-bit request.
`ifndef MUDB_DEFS_VH
`define MUDB_DEFS_VH

`define MUDB_AW 12
`define MUDB_DW 32

// Register offsets, same on both ports; the two queue port offsets decode on the PCI side only
`define MUDB_IMR0_OFS 12'h010
`define MUDB_IMR1_OFS 12'h014
`define MUDB_OMR0_OFS 12'h018
`define MUDB_OMR1_OFS 12'h01C
`define MUDB_IDR_OFS 12'h020
`define MUDB_IISR_OFS 12'h024
`define MUDB_IIMR_OFS 12'h028
`define MUDB_ODR_OFS 12'h02C
`define MUDB_OISR_OFS 12'h030
`define MUDB_OIMR_OFS 12'h034
`define MUDB_ODMR_OFS 12'h038
`define MUDB_IQP_OFS 12'h040
`define MUDB_OQP_OFS 12'h044

// Status and mask field positions
`define MUDB_ST_MSG0 0
`define MUDB_ST_MSG1 1
`define MUDB_ST_DB 2
`define MUDB_ST_NMI 3
`define MUDB_ST_POST 4
`define MUDB_ST_W 5
`define MUDB_NMI_BIT 31

// Reset values
`define MUDB_REG_RST 32'h00000000
`define MUDB_ST_RST 5'h00

`endif

// File: hdl/mudb_w1c_reg.v
`timescale 1ns/1ps
`default_nettype none
// Sticky bits: hardware or one party sets, a write of ones clears; set wins
module mudb_w1c_reg #(
   parameter W = 32
) (
   // Clock and reset
   input wire clk_i,
   input wire rstn_i,
   // Set and clear vectors
   input wire [W-1:0] set_i,
   input wire [W-1:0] clr_i,
   // State
   output reg [W-1:0] q_o
);
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q_o <= {W{1'b0}};
      end else begin
         q_o <= (q_o & ~clr_i) | set_i;
      end
   end
endmodule // mudb_w1c_reg
`default_nettype wire

// File: hdl/mudb_pci_irq.v
`timescale 1ns/1ps
`default_nettype none
// Steers one interrupt request onto the open-drain pin chosen by the pin setting
module mudb_pci_irq (
   // Clock and reset
   input wire clk_i,
   input wire rstn_i,
   // Request and pin choice (1..4 = A..D, else none)
   input wire irq_i,
   input wire [7:0] pin_sel_i,
   // Open-drain pins, enable low while pulling low
   output wire [3:0] int_o,
   output reg [3:0] int_oe_n_o
);
   reg [3:0] drive_d;

   assign int_o = 4'h0;

   always @* begin
      drive_d = 4'h0;
      case (pin_sel_i)
         8'h01: drive_d = {3'h0, irq_i};
         8'h02: drive_d = {2'h0, irq_i, 1'b0};
         8'h03: drive_d = {1'h0, irq_i, 2'h0};
         8'h04: drive_d = {irq_i, 3'h0};
         default: drive_d = 4'h0;
      endcase
   end

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_oe_n_o <= 4'hF;
      end else begin
         int_oe_n_o <= ~drive_d;
      end
   end
endmodule // mudb_pci_irq
`default_nettype wire

// File: sim/mudb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mudb_monitor (
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   // Core bus
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // PCI target side
   input wire logic P_VALID_I,
   input wire logic P_WRITE_I,
   input wire logic [11:0] P_ADDR_I,
   input wire logic [31:0] P_WDATA_I,
   input wire logic [3:0] P_BE_I,
   input wire logic P_REQ64_I,
   input wire logic P_READY_O,
   input wire logic P_ACK64_O,
   input wire logic [7:0] XLAT_INT_PIN_I,
   // Queue strobes and pins
   input wire logic IPQ_WR_O,
   input wire logic [31:0] IPQ_DATA_O,
   input wire logic IFQ_RD_O,
   input wire logic OPQ_RD_O,
   input wire logic OFQ_WR_O,
   input wire logic [31:0] OFQ_DATA_O,
   input wire logic [3:0] P_INT_O,
   input wire logic [3:0] P_INT_OE_N_O
);
   // A request counts only when the previous answer is not standing
   wire tk = P_VALID_I && !P_READY_O;
   wire qp = (P_ADDR_I == 12'h040) || (P_ADDR_I == 12'h044);
   wire wr40 = tk && P_WRITE_I && P_ADDR_I == 12'h040 && P_BE_I != 4'h0;
   wire rd40 = tk && !P_WRITE_I && P_ADDR_I == 12'h040 && P_BE_I != 4'h0;
   wire wr44 = tk && P_WRITE_I && P_ADDR_I == 12'h044 && P_BE_I != 4'h0;
   wire rd44 = tk && !P_WRITE_I && P_ADDR_I == 12'h044 && P_BE_I != 4'h0;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   ////////////////////////////////////////
   property p_answer; tk |=> P_READY_O ##1 !P_READY_O; endproperty
   a_answer: assert property (p_answer) else $error("pci answer late");
   property p_ack_q; tk && P_REQ64_I && qp |=> !P_ACK64_O; endproperty
   a_ack_q: assert property (p_ack_q) else $error("wide ack on queue port");
   property p_ack_r; tk && P_REQ64_I && !qp |=> P_ACK64_O; endproperty
   a_ack_r: assert property (p_ack_r) else $error("wide ack missing");
   property p_post; wr40 |=> IPQ_WR_O && IPQ_DATA_O == $past(P_WDATA_I); endproperty
   a_post: assert property (p_post) else $error("post strobe wrong");
   property p_null;
      tk && qp && P_BE_I == 4'h0 |=> !(IPQ_WR_O || IFQ_RD_O || OPQ_RD_O || OFQ_WR_O);
   endproperty
   a_null: assert property (p_null) else $error("null enables moved a queue");
   property p_ifree; rd40 |=> IFQ_RD_O && !IPQ_WR_O; endproperty
   a_ifree: assert property (p_ifree) else $error("free read strobe wrong");
   property p_ofree; wr44 |=> OFQ_WR_O && OFQ_DATA_O == $past(P_WDATA_I); endproperty
   a_ofree: assert property (p_ofree) else $error("free write strobe wrong");
   property p_opost; rd44 |=> OPQ_RD_O && !OFQ_WR_O; endproperty
   a_opost: assert property (p_opost) else $error("post read strobe wrong");
   property p_nopin; (XLAT_INT_PIN_I == 8'h00) [*3] |-> P_INT_OE_N_O == 4'hF; endproperty
   a_nopin: assert property (p_nopin) else $error("pin driven with no pin");
   property p_onepin; P_INT_OE_N_O != 4'hF |-> $onehot(~P_INT_OE_N_O) && P_INT_O == 4'h0;
   endproperty
   a_onepin: assert property (p_onepin) else $error("more than one pin");
   property p_unmap; PSEL_I && PENABLE_I && PADDR_I[11:6] != 6'h00 |-> PSLVERR_O && PREADY_O;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped not refused");
endmodule // mudb_monitor
bind mudb_top mudb_monitor i_mudb_monitor (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
   .PSLVERR_O(PSLVERR_O), .P_VALID_I(P_VALID_I), .P_WRITE_I(P_WRITE_I), .P_ADDR_I(P_ADDR_I),
   .P_WDATA_I(P_WDATA_I), .P_BE_I(P_BE_I), .P_REQ64_I(P_REQ64_I), .P_READY_O(P_READY_O),
   .P_ACK64_O(P_ACK64_O), .XLAT_INT_PIN_I(XLAT_INT_PIN_I), .IPQ_WR_O(IPQ_WR_O),
   .IPQ_DATA_O(IPQ_DATA_O), .IFQ_RD_O(IFQ_RD_O), .OPQ_RD_O(OPQ_RD_O), .OFQ_WR_O(OFQ_WR_O),
   .OFQ_DATA_O(OFQ_DATA_O), .P_INT_O(P_INT_O), .P_INT_OE_N_O(P_INT_OE_N_O));
`default_nettype wire

// File: sim/mudb_pci_agent.sv
`timescale 1ns/1ps
`default_nettype none
// External agent plus queue engine data; one word per request, held until answered
module mudb_pci_agent (
   // Clock
   input wire logic clk_i,
   // Request
   output logic valid_o,
   output logic write_o,
   output logic [11:0] addr_o,
   output logic [31:0] wdata_o,
   output logic [3:0] be_o,
   output logic req64_o,
   // Answer
   input wire logic ready_i,
   input wire logic [31:0] rdata_i,
   input wire logic ack64_i,
   // Queue engine data
   output logic [31:0] ifq_data_o,
   output logic [31:0] opq_data_o
);
   initial begin
      valid_o = 1'b0;
      write_o = 1'b0;
      addr_o = 12'hFFF;
      wdata_o = 32'h0;
      be_o = 4'h0;
      req64_o = 1'b0;
      ifq_data_o = 32'hF00D0001;
      opq_data_o = 32'h0BAD0002;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] be, input logic r64, input int gap, output logic [31:0] rd,
      output logic ack);
      repeat (gap) @(posedge clk_i);
      valid_o <= 1'b1;
      write_o <= w;
      addr_o <= a;
      wdata_o <= d;
      be_o <= be;
      req64_o <= r64;
      @(posedge clk_i);
      while (ready_i !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = rdata_i;
      ack = ack64_i;
      // Released lines show garbage, not the last value
      valid_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
      be_o <= ~be;
      @(posedge clk_i);
   endtask
endmodule // mudb_pci_agent
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, iwq_empty = 1, ak, er;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [7:0] pin = 8'h01;
   wire pready, pslverr, p_valid, p_write, p_req64, p_ready, p_ack64;
   wire ipq_wr, ifq_rd, opq_rd, ofq_wr, core_irq, core_nmi;
   wire [11:0] p_addr;
   wire [31:0] prdata, p_wdata, p_rdata, ifq_d, opq_d, ipq_d, ofq_d;
   wire [3:0] p_be, pint, oe_n;
   int bad_count = 0, compares = 0, cyc = 0;
   always #12.5 clk = ~clk;
   mudb_top i_mudb_top (.SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .P_VALID_I(p_valid), .P_WRITE_I(p_write), .P_ADDR_I(p_addr),
      .P_WDATA_I(p_wdata), .P_BE_I(p_be), .P_REQ64_I(p_req64), .P_READY_O(p_ready),
      .P_RDATA_O(p_rdata), .P_ACK64_O(p_ack64), .XLAT_IWQ_EMPTY_I(iwq_empty),
      .XLAT_INT_PIN_I(pin), .IPQ_WR_O(ipq_wr), .IPQ_DATA_O(ipq_d), .IFQ_RD_O(ifq_rd),
      .IFQ_DATA_I(ifq_d), .OPQ_RD_O(opq_rd), .OPQ_DATA_I(opq_d), .OFQ_WR_O(ofq_wr),
      .OFQ_DATA_O(ofq_d), .CORE_IRQ_O(core_irq), .CORE_NMI_O(core_nmi), .P_INT_O(pint),
      .P_INT_OE_N_O(oe_n));
   mudb_pci_agent i_pci (.clk_i(clk), .valid_o(p_valid), .write_o(p_write), .addr_o(p_addr),
      .wdata_o(p_wdata), .be_o(p_be), .req64_o(p_req64), .ready_i(p_ready), .rdata_i(p_rdata),
      .ack64_i(p_ack64), .ifq_data_o(ifq_d), .opq_data_o(opq_d));
   ////////////////////////////////////////
   task finish_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count++;
         finish_test;
      end
   end
   task chk_w(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: word %h expected %h", $time, g, e);
      end
   endtask
   task chk_b(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: flag %b expected %b", $time, g, e);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task cw(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
   task cr(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
   task pw(input logic [11:0] a, input logic [31:0] d); i_pci.xfer(1, a, d, 4'hF, 0, 0, rd, ak);
   endtask
   task pr(input logic [11:0] a); i_pci.xfer(0, a, 32'h0, 4'hF, 0, 1, rd, ak); endtask
   ////////////////////////////////////////
   task t_inmsg;
      cr(12'h024); chk_w(rd, 32'h0);
      cr(12'h0FC); chk_b(er, 1'b1);
      pw(12'h010, 32'hA5); wt(3); cr(12'h010); chk_w(rd, 32'hA5);
      cr(12'h024); chk_w(rd, 32'h1); chk_b(core_irq, 1'b1);
      cw(12'h024, 32'h0); cr(12'h024); chk_w(rd, 32'h1);
      cw(12'h024, 32'h1); wt(2); chk_b(core_irq, 1'b0);
      cw(12'h028, 32'h2); pw(12'h014, 32'h7); wt(3); chk_b(core_irq, 1'b0);
      cr(12'h024); chk_w(rd, 32'h2);
      cw(12'h024, 32'h2); cw(12'h028, 32'h0);
   endtask
   task t_outmsg;
      for (int k = 1; k < 5; k++) begin
         pin <= 8'(k); cw(12'h018, 32'(k)); wt(4);
         chk_w({28'h0, oe_n}, {28'h0, 4'hF ^ (4'h1 << (k - 1))});
         pr(12'h030); chk_w(rd, 32'h1);
         pw(12'h030, 32'h1); wt(4); chk_w({28'h0, oe_n}, 32'hF);
      end
      pw(12'h034, 32'h2); cw(12'h01C, 32'h3); wt(4); chk_w({28'h0, oe_n}, 32'hF);
      pr(12'h01C); chk_w(rd, 32'h3);
      pw(12'h034, 32'h0); wt(4); chk_w({28'h0, oe_n}, 32'h7);
      pin <= 8'h00; wt(4); chk_w({28'h0, oe_n}, 32'hF);
      pw(12'h030, 32'h0); pr(12'h030); chk_w(rd, 32'h2);
      pw(12'h030, 32'h2); pin <= 8'h01;
   endtask
   task t_odb;
      cw(12'h02C, 32'h5); cw(12'h02C, 32'h4); pr(12'h02C); chk_w(rd, 32'h5);
      wt(3); chk_w({28'h0, oe_n}, 32'hE);
      pw(12'h038, 32'h5); wt(4); chk_w({28'h0, oe_n}, 32'hF);
      pr(12'h02C); chk_w(rd, 32'h5);
      pw(12'h038, 32'h1); wt(4); chk_w({28'h0, oe_n}, 32'hE);
      pw(12'h02C, 32'h0); pr(12'h02C); chk_w(rd, 32'h5);
      pw(12'h02C, 32'h4); pr(12'h02C); chk_w(rd, 32'h1);
      wt(4); chk_w({28'h0, oe_n}, 32'hF);
      pw(12'h02C, 32'h1); pw(12'h038, 32'h0);
   endtask
   task t_idb;
      pw(12'h020, 32'h3); pw(12'h020, 32'h1); cr(12'h020); chk_w(rd, 32'h3);
      cr(12'h024); chk_w(rd, 32'h4); chk_b(core_irq, 1'b1);
      cw(12'h028, 32'h4); wt(3); chk_b(core_irq, 1'b0);
      cr(12'h020); chk_w(rd, 32'h3);
      pw(12'h020, 32'h80000000); wt(3); chk_b(core_nmi, 1'b1);
      cw(12'h020, 32'h1); cw(12'h020, 32'h0); cr(12'h020); chk_w(rd, 32'h80000002);
      cw(12'h020, 32'h80000002); wt(3); chk_b(core_nmi, 1'b0);
      cw(12'h028, 32'h0);
   endtask
   task t_queue;
      iwq_empty <= 1'b0;
      pw(12'h040, 32'h1234); wt(5); chk_b(core_irq, 1'b0);
      cr(12'h024); chk_w(rd, 32'h0);
      iwq_empty <= 1'b1; wt(4); chk_b(core_irq, 1'b1);
      cr(12'h024); chk_w(rd, 32'h10); cw(12'h024, 32'h10);
      pr(12'h040); chk_w(rd, 32'hF00D0001);
      pr(12'h044); chk_w(rd, 32'h0BAD0002);
      i_pci.xfer(1, 12'h044, 32'h77, 4'hF, 1, 0, rd, ak); chk_b(ak, 1'b0);
      i_pci.xfer(0, 12'h010, 32'h0, 4'hF, 1, 2, rd, ak); chk_b(ak, 1'b1);
      i_pci.xfer(1, 12'h040, 32'h99, 4'h0, 0, 0, rd, ak); wt(4);
      chk_b(core_irq, 1'b0);
   endtask
   initial begin
      wt(4);
      rstn <= 1'b1;
      wt(1);
      t_inmsg;
      t_outmsg;
      t_odb;
      t_idb;
      t_queue;
      finish_test;
   end
endmodule // testbench
`default_nettype wire
